// File: src/cts_consts.svh
// Named constants for the command timing supervisor.
`ifndef CTS_CONSTS_SVH
`define CTS_CONSTS_SVH

// Core clock frequency and millisecond prescale.
`define CTS_CLK_HZ        25000000
`define CTS_MS_PER_S      1000
`define CTS_CYC_PER_MS    (`CTS_CLK_HZ / `CTS_MS_PER_S)

// Command durations and hard limits in milliseconds.
`define CTS_DUR_SHORT_MS  20
`define CTS_DUR_LONG_MS   750
`define CTS_DUR_FULL_MS   1000
`define CTS_TMO_SHORT_MS  750
`define CTS_TMO_LONG_MS   2000

// Interface timeout class defaults in milliseconds.
`define CTS_TMO_A_MS      750
`define CTS_TMO_B_MS      2000
`define CTS_TMO_C_MS      200
`define CTS_TMO_D_MS      30

// Register offsets (word addresses on the plain port).
`define CTS_REG_CTRL      4'h0
`define CTS_REG_FIFOSTS   4'h1
`define CTS_REG_CRBCTRL   4'h2
`define CTS_REG_CLASS     4'h3
`define CTS_REG_ELAPSED   4'h4
`define CTS_REG_IFTMO     4'h5
`define CTS_REG_IRQSTS    4'h6
`define CTS_REG_IRQMSK    4'h7

// Field positions.
`define CTS_CTRL_NVREAD   2
`define CTS_CTRL_OSUP     3
`define CTS_CTRL_DONE     4
`define CTS_FIFO_GO       0
`define CTS_FIFO_AVAIL    1
`define CTS_FIFO_VALID    2
`define CTS_CRB_START     0
`define CTS_IRQ_DURATION  0
`define CTS_IRQ_TIMEOUT   1
`define CTS_IRQ_DONE      2
`define CTS_IRQ_INIT      3
`define CTS_IRQ_IFTMO     4
`define CTS_IRQ_W         5

`endif

// File: src/cts_pkg.sv
// Types shared by the command timing supervisor.
package cts_pkg;
   // Command timing classes by limit pair.
   typedef enum logic [1:0] {
      CTS_CLS_SHORT = 2'h0,
      CTS_CLS_LONG  = 2'h1,
      CTS_CLS_FULL  = 2'h2
   } cts_class_t;

   // Execution states, one-hot.
   typedef enum logic [2:0] {
      CTS_ST_IDLE = 3'h1,
      CTS_ST_RUN  = 3'h2,
      CTS_ST_DONE = 3'h4
   } cts_state_t;
endpackage

// File: src/cts_ms_timer.sv
// Millisecond prescaler and elapsed-millisecond counter.
`timescale 1ns/100ps
`default_nettype none
`include "cts_consts.svh"
module cts_ms_timer #(
   parameter int CYC_PER_MS = `CTS_CYC_PER_MS,
   parameter int CNT_W      = 16
) (
   input  wire logic             mclk,
   input  wire logic             reset_n,
   input  wire logic             clkEn,
   input  wire logic             clear,
   input  wire logic             run,
   output logic                  msTick,
   output logic [CNT_W-1:0]      msCount
);
   localparam int PW = $clog2(CYC_PER_MS + 1);
   logic [PW-1:0] preCnt_ff;

   // Prescaler restarts on clear so a new interval starts at a full millisecond.
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         preCnt_ff <= '0;
         msTick    <= 1'b0;
      end else if (clkEn) begin
         msTick <= 1'b0;
         if (clear || !run) begin
            preCnt_ff <= '0;
         end else if (preCnt_ff == PW'(CYC_PER_MS - 1)) begin
            preCnt_ff <= '0;
            msTick    <= 1'b1;
         end else begin
            preCnt_ff <= preCnt_ff + 1'b1;
         end
      end
   end

   // Counter saturates instead of wrapping, so a hung command stays flagged.
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         msCount <= '0;
      end else if (clkEn) begin
         if (clear) begin
            msCount <= '0;
         end else if (msTick && msCount != '1) begin
            msCount <= msCount + 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// File: src/cts_supervisor.sv
// Command timing supervisor: execution timing, completion and init handling.
//
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "cts_consts.svh"
module cts_supervisor
   import cts_pkg::*;
#(
   parameter int CYC_PER_MS = `CTS_CYC_PER_MS,
   parameter int MS_W       = 16
) (
   input  wire logic        mclk,
   input  wire logic        reset_n,
   input  wire logic        clkEn,
   input  wire logic        busReset_n,
   input  wire logic [3:0]  regAddr,
   input  wire logic [31:0] regWrData,
   input  wire logic        regWrStb,
   input  wire logic        regRdStb,
   output logic [31:0]      regRdData,
   output logic             irq,
   output logic             platformInitPulse,
   output logic             trustRootReset,
   output logic             cmdBusy
);
   // ****************************************************************
   // Declarations
   // ****************************************************************
   cts_state_t        state_ff;
   cts_class_t        class_ff;
   logic              nvRead_ff;
   logic              osUp_ff;
   logic              goReq_ff;
   logic              respAvail_ff;
   logic              status_valid_flag_ff;
   logic              crbStart_ff;
   logic              durOver_ff;
   logic              tmoOver_ff;
   logic              busRstQ_ff;
   logic [1:0]        ifClass_ff;
   logic              ifArm_ff;
   logic              ifOver_ff;
   logic [`CTS_IRQ_W-1:0] irqSts_ff;
   logic [`CTS_IRQ_W-1:0] irqMsk_ff;
   logic [`CTS_IRQ_W-1:0] irqEvt;
   logic              initEvt;
   logic              goWr;
   logic              startWr;
   logic              doneWr;
   logic              cmdStart;
   logic              cmdDone;
   logic              timerClr;
   logic              msTickCmd;
   logic [MS_W-1:0]   msElapsed;
   logic              msTickIf;
   logic [MS_W-1:0]   msIf;
   logic [MS_W-1:0]   durLimit;
   logic [MS_W-1:0]   tmoLimit;
   logic [MS_W-1:0]   ifLimit;
   logic              limitsApply;
   logic              wrCtrl;

   // ****************************************************************
   // Platform init detection
   // ****************************************************************
   // The pin is sampled once; a low-to-high step is the init indication.
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         busRstQ_ff <= 1'b0;
      end else if (clkEn) begin
         busRstQ_ff <= busReset_n;
      end
   end

   assign initEvt = clkEn && busReset_n && !busRstQ_ff;

   // Init pulses out to the root-of-trust logic for one cycle.
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         platformInitPulse <= 1'b0;
         trustRootReset    <= 1'b0;
      end else if (clkEn) begin
         platformInitPulse <= initEvt;
         trustRootReset    <= initEvt;
      end
   end

   // ****************************************************************
   // Write decode
   // ****************************************************************
   assign wrCtrl  = regWrStb && regAddr == `CTS_REG_CTRL;
   assign goWr    = regWrStb && regAddr == `CTS_REG_FIFOSTS && regWrData[`CTS_FIFO_GO];
   assign startWr = regWrStb && regAddr == `CTS_REG_CRBCTRL && regWrData[`CTS_CRB_START];
   assign doneWr  = wrCtrl && regWrData[`CTS_CTRL_DONE];
   // A new start is only taken while not running (idle or done); a repeat write during execution is ignored.
   assign cmdStart = clkEn && !initEvt && (goWr || startWr)
                     && (state_ff != CTS_ST_RUN);
   assign cmdDone  = clkEn && !initEvt && doneWr && state_ff == CTS_ST_RUN;
   assign timerClr = initEvt || cmdStart;

   // ****************************************************************
   // Execution state machine
   // ****************************************************************
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_ff <= CTS_ST_IDLE;
      end else if (clkEn) begin
         if (initEvt) begin
            state_ff <= CTS_ST_IDLE;
         end else begin
            case (state_ff)
               CTS_ST_IDLE: begin
                  if (cmdStart) state_ff <= CTS_ST_RUN;
               end
               CTS_ST_RUN: begin
                  if (doneWr) state_ff <= CTS_ST_DONE;
               end
               CTS_ST_DONE: begin
                  if (cmdStart) state_ff <= CTS_ST_RUN;
               end
               default: state_ff <= CTS_ST_IDLE;
            endcase
         end
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cmdBusy <= 1'b0;
      end else if (clkEn) begin
         if (initEvt || cmdDone) cmdBusy <= 1'b0;
         else if (cmdStart) cmdBusy <= 1'b1;
      end
   end

   // ****************************************************************
   // Completion indications
   // ****************************************************************
   // Response and valid flags drop on a FIFO go start as go rises; at completion go drops and they rise together.
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         goReq_ff     <= 1'b0;
         respAvail_ff <= 1'b0;
         status_valid_flag_ff  <= 1'b0;
      end else if (clkEn) begin
         if (initEvt) begin
            goReq_ff     <= 1'b0;
            respAvail_ff <= 1'b0;
            status_valid_flag_ff  <= 1'b0;
         end else if (cmdDone) begin
            goReq_ff     <= 1'b0;
            respAvail_ff <= 1'b1;
            status_valid_flag_ff  <= 1'b1;
         end else if (cmdStart && goWr) begin
            goReq_ff     <= 1'b1;
            respAvail_ff <= 1'b0;
            status_valid_flag_ff  <= 1'b0;
         end
      end
   end

   // Start bit stays set for the whole execution, then clears as completion.
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         crbStart_ff <= 1'b0;
      end else if (clkEn) begin
         if (initEvt || cmdDone) crbStart_ff <= 1'b0;
         else if (cmdStart && startWr) crbStart_ff <= 1'b1;
      end
   end

   // ****************************************************************
   // Command class and environment control
   // ****************************************************************
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         class_ff   <= CTS_CLS_SHORT;
         nvRead_ff  <= 1'b0;
         osUp_ff    <= 1'b0;
         ifClass_ff <= 2'h0;
      end else if (clkEn) begin
         if (initEvt) begin
            osUp_ff <= 1'b0;
         end else if (wrCtrl) begin
            nvRead_ff <= regWrData[`CTS_CTRL_NVREAD];
            osUp_ff   <= regWrData[`CTS_CTRL_OSUP];
         end
         if (regWrStb && regAddr == `CTS_REG_CLASS) begin
            case (regWrData[1:0])
               2'h1:    class_ff <= CTS_CLS_LONG;
               2'h2:    class_ff <= CTS_CLS_FULL;
               default: class_ff <= CTS_CLS_SHORT;
            endcase
         end
         if (regWrStb && regAddr == `CTS_REG_IFTMO) ifClass_ff <= regWrData[1:0];
      end
   end

   // ****************************************************************
   // Limits per class
   // ****************************************************************
   always_comb begin
      case (class_ff)
         CTS_CLS_LONG: begin
            durLimit = MS_W'(`CTS_DUR_LONG_MS);
            tmoLimit = MS_W'(`CTS_TMO_LONG_MS);
         end
         CTS_CLS_FULL: begin
            durLimit = MS_W'(`CTS_DUR_FULL_MS);
            tmoLimit = MS_W'(`CTS_TMO_LONG_MS);
         end
         default: begin
            durLimit = MS_W'(`CTS_DUR_SHORT_MS);
            tmoLimit = MS_W'(`CTS_TMO_SHORT_MS);
         end
      endcase
      case (ifClass_ff)
         2'h1:    ifLimit = MS_W'(`CTS_TMO_B_MS);
         2'h2:    ifLimit = MS_W'(`CTS_TMO_C_MS);
         2'h3:    ifLimit = MS_W'(`CTS_TMO_D_MS);
         default: ifLimit = MS_W'(`CTS_TMO_A_MS);
      endcase
   end

   // Nonvolatile reads are not policed once the OS runs.
   assign limitsApply = !(nvRead_ff && osUp_ff);

   // ****************************************************************
   // Millisecond timers
   // ****************************************************************
   cts_ms_timer #(
      .CYC_PER_MS (CYC_PER_MS),
      .CNT_W      (MS_W)
   ) uCmdTimer (
      .mclk    (mclk),
      .reset_n (reset_n),
      .clkEn   (clkEn),
      .clear   (timerClr),
      .run     (state_ff == CTS_ST_RUN),
      .msTick  (msTickCmd),
      .msCount (msElapsed)
   );

   // Interface timer restarts on any register access, the protocol transition.
   cts_ms_timer #(
      .CYC_PER_MS (CYC_PER_MS),
      .CNT_W      (MS_W)
   ) uIfTimer (
      .mclk    (mclk),
      .reset_n (reset_n),
      .clkEn   (clkEn),
      .clear   (initEvt || regWrStb || regRdStb),
      .run     (ifArm_ff),
      .msTick  (msTickIf),
      .msCount (msIf)
   );

   // ****************************************************************
   // Overrun flags
   // ****************************************************************
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         durOver_ff <= 1'b0;
         tmoOver_ff <= 1'b0;
      end else if (clkEn) begin
         if (timerClr) begin
            durOver_ff <= 1'b0;
            tmoOver_ff <= 1'b0;
         end else if (state_ff == CTS_ST_RUN && limitsApply) begin
            if (msElapsed >= durLimit) durOver_ff <= 1'b1;
            if (msElapsed >= tmoLimit) tmoOver_ff <= 1'b1;
         end
      end
   end

   // Interface watch is armed while a command runs.
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ifArm_ff  <= 1'b0;
         ifOver_ff <= 1'b0;
      end else if (clkEn) begin
         ifArm_ff <= (state_ff == CTS_ST_RUN);
         if (initEvt || regWrStb || regRdStb) ifOver_ff <= 1'b0;
         else if (ifArm_ff && msIf >= ifLimit) ifOver_ff <= 1'b1;
      end
   end

   // ****************************************************************
   // Interrupts
   // ****************************************************************
   assign irqEvt[`CTS_IRQ_DURATION] = state_ff == CTS_ST_RUN && limitsApply
                                      && msElapsed >= durLimit && !durOver_ff;
   assign irqEvt[`CTS_IRQ_TIMEOUT]  = state_ff == CTS_ST_RUN && limitsApply
                                      && msElapsed >= tmoLimit && !tmoOver_ff;
   assign irqEvt[`CTS_IRQ_DONE]     = cmdDone;
   assign irqEvt[`CTS_IRQ_INIT]     = initEvt;
   assign irqEvt[`CTS_IRQ_IFTMO]    = ifArm_ff && msIf >= ifLimit && !ifOver_ff;

   // A set in the same cycle as a write-one-to-clear wins.
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         irqSts_ff <= '0;
         irqMsk_ff <= '0;
         irq       <= 1'b0;
      end else if (clkEn) begin
         if (regWrStb && regAddr == `CTS_REG_IRQSTS) begin
            irqSts_ff <= (irqSts_ff & ~regWrData[`CTS_IRQ_W-1:0]) | irqEvt;
         end else begin
            irqSts_ff <= irqSts_ff | irqEvt;
         end
         if (regWrStb && regAddr == `CTS_REG_IRQMSK) irqMsk_ff <= regWrData[`CTS_IRQ_W-1:0];
         irq <= |(irqSts_ff & irqMsk_ff);
      end
   end

   // ****************************************************************
   // Read port
   // ****************************************************************
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         regRdData <= '0;
      end else if (clkEn) begin
         regRdData <= '0;
         if (regRdStb) begin
            case (regAddr)
               `CTS_REG_CTRL:    regRdData <= {27'h0, 1'b0, osUp_ff, nvRead_ff,
                                               tmoOver_ff, durOver_ff};
               `CTS_REG_FIFOSTS: regRdData <= {29'h0, status_valid_flag_ff, respAvail_ff, goReq_ff};
               `CTS_REG_CRBCTRL: regRdData <= {31'h0, crbStart_ff};
               `CTS_REG_CLASS:   regRdData <= {30'h0, class_ff};
               `CTS_REG_ELAPSED: regRdData <= 32'(msElapsed);
               `CTS_REG_IFTMO:   regRdData <= {30'h0, ifClass_ff};
               `CTS_REG_IRQSTS:  regRdData <= 32'(irqSts_ff);
               `CTS_REG_IRQMSK:  regRdData <= 32'(irqMsk_ff);
               default:          regRdData <= '0;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// File: dv/cts_supervisor_sva.sv
// Port-level checker of the command timing supervisor.
`timescale 1ns/100ps
`default_nettype none
`include "cts_consts.svh"
module cts_supervisor_sva (
   input wire logic        mclk,
   input wire logic        reset_n,
   input wire logic        clkEn,
   input wire logic        busReset_n,
   input wire logic [3:0]  regAddr,
   input wire logic [31:0] regWrData,
   input wire logic        regWrStb,
   input wire logic        regRdStb,
   input wire logic [31:0] regRdData,
   input wire logic        irq,
   input wire logic        platformInitPulse,
   input wire logic        trustRootReset,
   input wire logic        cmdBusy
);
   // ****************
   // Decoded requests
   // ****************
   // Start and completion writes as the supervisor takes them.
   wire logic goWr  = clkEn && regWrStb && regAddr == `CTS_REG_FIFOSTS && regWrData[0];
   wire logic crbWr = clkEn && regWrStb && regAddr == `CTS_REG_CRBCTRL && regWrData[0];
   wire logic doneWr = clkEn && regWrStb && regAddr == `CTS_REG_CTRL && regWrData[4];

   // ****************
   // Assertions
   // ****************
   // The pin must be quiet around a start, since an init would legally abort it.
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!reset_n);

   a_go_starts: assert property (goWr && !cmdBusy && busReset_n && $stable(busReset_n) |=> cmdBusy)
      else $error("fifo go write did not start a command");
   a_crb_starts: assert property (crbWr && !cmdBusy && busReset_n && $stable(busReset_n) |=> cmdBusy)
      else $error("crb start write did not start a command");
   a_done_ends: assert property (cmdBusy && doneWr |=> !cmdBusy)
      else $error("completion did not end the command");
   a_busy_holds: assert property (cmdBusy && !doneWr && busReset_n && $stable(busReset_n) |=> cmdBusy)
      else $error("command ended without completion or init");
   a_init_on_rise: assert property ($rose(busReset_n) |=> platformInitPulse)
      else $error("pin rise gave no init pulse");
   a_init_cause: assert property (platformInitPulse |-> $past(busReset_n) && !$past(busReset_n, 2))
      else $error("init pulse without a pin rise");
   a_init_single: assert property (platformInitPulse |=> !platformInitPulse)
      else $error("init pulse longer than one cycle");
   a_roots_reset: assert property (trustRootReset == platformInitPulse)
      else $error("trust root reset not aligned with init");
   a_init_idles: assert property (platformInitPulse |-> !cmdBusy)
      else $error("command still busy after init");

   // Main scenarios reached.
   c_init: cover property (platformInitPulse);
   c_done: cover property (cmdBusy ##1 !cmdBusy);
   c_irq: cover property ($rose(irq));
endmodule
`default_nettype wire

// File: dv/cts_host_model.sv
// Host driver model: register bus master and platform reset pin.
`timescale 1ns/100ps
`default_nettype none
`include "cts_consts.svh"
module cts_host_model (
   input  wire logic   mclk,
   output logic [3:0]  regAddr,
   output logic [31:0] regWrData,
   output logic        regWrStb,
   output logic        regRdStb,
   output logic        busReset_n
);
   // Idle bus and the pin held low until the platform powers on.
   initial begin
      regAddr = 4'h0;
      regWrData = 32'h0;
      regWrStb = 1'b0;
      regRdStb = 1'b0;
      busReset_n = 1'b0;
   end

   // One-cycle write; released data is scrambled so stale values cannot pass.
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk);
      regAddr <= a;
      regWrData <= d;
      regWrStb <= 1'b1;
      @(posedge mclk);
      regWrStb <= 1'b0;
      regWrData <= ~d;
   endtask

   // One-cycle read; the data is taken by the bench monitor.
   task automatic rd(input logic [3:0] a);
      @(posedge mclk);
      regAddr <= a;
      regRdStb <= 1'b1;
      @(posedge mclk);
      regRdStb <= 1'b0;
      regAddr <= ~a;
   endtask

   // Power-on init: pin low for a while, then raised.
   task automatic init(input int lowCycles);
      @(posedge mclk);
      busReset_n <= 1'b0;
      repeat (lowCycles) @(posedge mclk);
      busReset_n <= 1'b1;
   endtask

   // Give up on a command once its timeout has run by ending it.
   task automatic cancel();
      wr(`CTS_REG_CTRL, 32'h10);
   endtask
endmodule
`default_nettype wire

// File: dv/cts_supervisor_test.sv
// Self-checking testbench of the command timing supervisor.
`timescale 1ns/100ps
`default_nettype none
`default_nettype none
`include "cts_consts.svh"
module cts_supervisor_test;
   localparam int CPM = 10;
   logic        mclk;
   logic        reset_n;
   logic        clkEn;
   logic [3:0]  regAddr;
   logic [31:0] regWrData;
   logic        regWrStb;
   logic        regRdStb;
   logic        busReset_n;
   logic [31:0] regRdData;
   logic        irq;
   logic        platformInitPulse;
   logic        trustRootReset;
   logic        cmdBusy;
   logic        rdPend = 1'b0;
   logic [63:0] expQ[$];
   logic [63:0] note;
   logic [3:0]  a;
   int          nFail = 0;
   int          checkCount = 0;
   int          seed;
   int          durMs[3] = '{20, 750, 1000};
   int          tmoMs[3] = '{750, 2000, 2000};
   int          ifMs[4] = '{750, 2000, 200, 30};

   // ****************
   // Harness
   // ****************
   // Clock at 25 MHz.
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   cts_host_model host (.mclk(mclk), .regAddr(regAddr), .regWrData(regWrData),
      .regWrStb(regWrStb), .regRdStb(regRdStb), .busReset_n(busReset_n));
   cts_supervisor #(.CYC_PER_MS(CPM)) dut (.mclk(mclk), .reset_n(reset_n), .clkEn(clkEn),
      .busReset_n(busReset_n), .regAddr(regAddr), .regWrData(regWrData),
      .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .irq(irq),
      .platformInitPulse(platformInitPulse), .trustRootReset(trustRootReset),
      .cmdBusy(cmdBusy));

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checkCount++;
      if (seen !== exp) begin
         nFail++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Note the expected masked value, then issue the read.
   task automatic rd(input logic [3:0] ad, input logic [31:0] exp, input logic [31:0] msk);
      expQ.push_back({exp, msk});
      host.rd(ad);
   endtask

   task automatic waitc(input int n);
      repeat (n) @(posedge mclk);
   endtask

   task automatic end_sim();
      if (nFail == 0 && checkCount > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Read data stands only in the cycle after the strobe, so it is taken one edge later.
   always @(posedge mclk) begin
      if (rdPend && expQ.size() > 0) begin
         note = expQ.pop_front();
         chk("regRdData", regRdData & note[31:0], note[63:32]);
      end
      rdPend <= reset_n && regRdStb;
   end

   // Watchdog sized well above the longest command sequence.
   initial begin
      repeat (85000) @(posedge mclk);
      nFail++;
      end_sim();
   end

   // ****************
   // Scenarios
   // ****************
   initial begin
      seed = 32'h214e96e3;
      reset_n = 1'b0;
      clkEn = 1'b1;
      waitc(12);
      reset_n <= 1'b1;
      host.init(3);
      waitc(1);
      #1 chk("initPulses", {30'h0, platformInitPulse, trustRootReset}, 32'h3);
      rd(`CTS_REG_FIFOSTS, 32'h0, 32'h7);
      rd(`CTS_REG_IRQSTS, 32'h8, 32'h8);
      // Unmapped places ignore random writes and read as zero.
      for (int i = 0; i < 4; i++) begin
         a = 4'h8 | 4'($random(seed));
         host.wr(a, $random(seed));
         rd(a, 32'h0, 32'hffffffff);
      end
      host.wr(`CTS_REG_IRQSTS, 32'h1f);
      host.wr(`CTS_REG_IRQMSK, 32'h4);
      // Every command class, through duration and hard limit; class 1 over the CRB path.
      for (int c = 0; c < 3; c++) begin
         host.wr(`CTS_REG_CLASS, 32'(c));
         if (c == 1) begin
            host.wr(`CTS_REG_CRBCTRL, 32'h1);
            rd(`CTS_REG_CRBCTRL, 32'h1, 32'h1);
         end else begin
            host.wr(`CTS_REG_FIFOSTS, 32'h1);
            rd(`CTS_REG_FIFOSTS, 32'h1, 32'h7);
         end
         waitc(CPM * durMs[c] - 20);
         rd(`CTS_REG_CTRL, 32'h0, 32'h3);
         waitc(40);
         rd(`CTS_REG_CTRL, 32'h1, 32'h3);
         waitc(CPM * (tmoMs[c] - durMs[c]) - 45);
         rd(`CTS_REG_CTRL, 32'h1, 32'h3);
         waitc(40);
         rd(`CTS_REG_CTRL, 32'h3, 32'h3);
         #1 chk("irq cmdBusy", {30'h0, irq, cmdBusy}, 32'h1);
         host.cancel();
         if (c == 1) begin
            rd(`CTS_REG_CRBCTRL, 32'h0, 32'h1);
         end else begin
            rd(`CTS_REG_FIFOSTS, 32'h6, 32'h7);
         end
         #1 chk("irq cmdBusy", {30'h0, irq, cmdBusy}, 32'h2);
         host.wr(`CTS_REG_IRQSTS, 32'h1f);
         waitc(3);
         #1 chk("irq", {31'h0, irq}, 32'h0);
      end
      // A nonvolatile read with the OS up is not held to the limits.
      host.wr(`CTS_REG_CTRL, 32'hc);
      host.wr(`CTS_REG_CLASS, 32'h1);
      host.wr(`CTS_REG_FIFOSTS, 32'h1);
      waitc(CPM * 750 + 20);
      rd(`CTS_REG_CTRL, 32'hc, 32'hf);
      host.cancel();
      // Init aborts a running command; the next command times from zero.
      host.wr(`CTS_REG_CLASS, 32'h0);
      host.wr(`CTS_REG_FIFOSTS, 32'h1);
      waitc(150);
      host.init(2);
      rd(`CTS_REG_FIFOSTS, 32'h0, 32'h7);
      rd(`CTS_REG_ELAPSED, 32'h0, 32'hffff);
      host.wr(`CTS_REG_FIFOSTS, 32'h1);
      // Freeze the block for 100 cycles; elapsed time must not move meanwhile.
      clkEn <= 1'b0;
      waitc(100);
      clkEn <= 1'b1;
      waitc(CPM * 20 - 40);
      rd(`CTS_REG_CTRL, 32'h0, 32'h3);
      host.cancel();
      // Interface classes read back; the two short ones are timed.
      for (int i = 0; i < 4; i++) begin
         host.wr(`CTS_REG_IFTMO, 32'(i));
         rd(`CTS_REG_IFTMO, 32'(i), 32'h3);
      end
      for (int i = 2; i < 4; i++) begin
         host.wr(`CTS_REG_IFTMO, 32'(i));
         host.wr(`CTS_REG_IRQSTS, 32'h1f);
         host.wr(`CTS_REG_FIFOSTS, 32'h1);
         waitc(CPM * ifMs[i] - 25);
         rd(`CTS_REG_IRQSTS, 32'h0, 32'h10);
         waitc(CPM * ifMs[i] + 20);
         rd(`CTS_REG_IRQSTS, 32'h10, 32'h10);
         host.cancel();
      end
      waitc(4);
      end_sim();
   end
endmodule

bind cts_supervisor cts_supervisor_sva chk (.mclk(mclk), .reset_n(reset_n), .clkEn(clkEn),
   .busReset_n(busReset_n), .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
   .regRdStb(regRdStb), .regRdData(regRdData), .irq(irq),
   .platformInitPulse(platformInitPulse), .trustRootReset(trustRootReset), .cmdBusy(cmdBusy));
`default_nettype wire
